// *** bench/line_partner.sv ***
// Line interface and transmit clock source model facing the channel block.
`timescale 1ns/1ps
module line_partner (
   input  wire logic run,
   input  wire logic tx_hold,
   input  wire logic rx_hold,
   input  wire logic nrz,
   input  wire logic rx_bit,
   output logic      tx_input_clock,
   output logic      rx_line_clock,
   output logic      rx_line_positive,
   output logic      rx_line_negative
);
   logic mark_neg = 1'b0;
   // Rates are scaled so each half period spans several sys_clk cycles.
   initial begin
      tx_input_clock = 1'b0;
      forever begin
         #43;
         tx_input_clock = run ? ~tx_input_clock : tx_hold;
      end
   end
   initial begin
      rx_line_clock = 1'b0;
      forever begin
         #47;
         rx_line_clock = run ? ~rx_line_clock : rx_hold;
      end
   end
   // Data moves on the falling edge so it is steady at the rise.
   always @(negedge rx_line_clock) begin
      rx_line_positive <= rx_bit & (nrz | ~mark_neg);
      rx_line_negative <= rx_bit & ~nrz & mark_neg;
      if (rx_bit & ~nrz)
         mark_neg <= ~mark_neg;
   end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the framer channel control block.
`timescale 1ns/1ps
`include "framer_ctl_consts.svh"
module tb_top;
   import framer_ctl_pkg::*;
   logic               sys_clk, srst = 1'b1;
   logic [`ADDR_W-1:0] reg_addr = '0;
   logic [`DATA_W-1:0] reg_wdata = '0, reg_rdata, hi, lo;
   logic               reg_write = 1'b0, reg_read = 1'b0;
   logic               tx_system_data = 1'b0, tx_overhead_data = 1'b0;
   logic               tx_overhead_enable = 1'b0, tx_frame_start_in = 1'b0;
   logic               tx_core_data = 1'b0, tx_core_enable = 1'b0;
   logic               tx_core_frame_start = 1'b0, rx_core_enable = 1'b0;
   logic               rx_core_frame_start = 1'b1, rx_core_loss = 1'b1;
   logic               rx_core_oof = 1'b0, run = 1'b1, nrz = 1'b0;
   logic               tx_hold = 1'b0, rx_hold = 1'b0, rx_bit = 1'b1;
   logic               tx_input_clock, rx_line_clock, rx_line_positive;
   logic               rx_line_negative, tx_frame_start_out;
   logic               tx_frame_start_oe, tx_data_enable, tx_line_positive;
   logic               tx_line_negative, tx_line_clock_out, rx_output_clock;
   logic               rx_system_data, rx_data_enable, rx_frame_start;
   logic               rx_loss_of_signal, rx_out_of_frame, line_code_enable;
   logic               core_tx_tick, core_tx_bit, core_tx_frame_start;
   logic               core_rx_tick, core_rx_bit, core_rx_violation;
   framing_t           framing_mode;
   int                 mismatches = 0, n_checks = 0;

   framer_channel_ctl framer_channel_ctl_inst (.sys_clk, .srst, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata, .tx_input_clock,
      .tx_system_data, .tx_overhead_data, .tx_overhead_enable,
      .tx_frame_start_in, .tx_frame_start_out, .tx_frame_start_oe,
      .tx_data_enable, .tx_line_positive, .tx_line_negative,
      .tx_line_clock_out, .rx_line_clock, .rx_line_positive,
      .rx_line_negative, .rx_output_clock, .rx_system_data, .rx_data_enable,
      .rx_frame_start, .rx_loss_of_signal, .rx_out_of_frame, .tx_core_data,
      .tx_core_enable, .tx_core_frame_start, .rx_core_enable,
      .rx_core_frame_start, .rx_core_loss, .rx_core_oof, .framing_mode,
      .line_code_enable, .core_tx_tick, .core_tx_bit, .core_tx_frame_start,
      .core_rx_tick, .core_rx_bit, .core_rx_violation);
   line_partner line_partner_inst (.run, .tx_hold, .rx_hold, .nrz, .rx_bit,
      .tx_input_clock, .rx_line_clock, .rx_line_positive, .rx_line_negative);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] e, g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bit_is(input string nm, input logic e, g);
      check(nm, {7'h0, e}, {7'h0, g});
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd_check(input logic [2:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      check("reg_rdata", e, reg_rdata);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // Records which of the rails and enable pins were seen high and low.
   task automatic watch(input int n);
      hi = '0;
      lo = '0;
      repeat (n) begin
         @(negedge sys_clk);
         hi |= {4'h0, tx_line_positive, tx_line_negative, rx_data_enable,
                tx_data_enable};
         lo |= ~{4'hF, tx_line_positive, tx_line_negative, rx_data_enable,
                 tx_data_enable};
      end
   endtask

   initial begin
      #100us;
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      rd_check(`REG_MODE, 8'h00);
      rd_check(`REG_LINE, `LINE_RESET);
      rd_check(`REG_SYSIF, 8'h00);
      rd_check(`REG_LOOP, 8'h00);
      rd_check(`REG_FORCE, 8'h00);
      rd_check(`REG_STATUS, 8'h0C);
      bit_is("rx_system_data", 1'b1, rx_system_data);
      bit_is("tx_frame_start_oe", 1'b0, tx_frame_start_oe);
      bit_is("rx_loss_of_signal", 1'b1, rx_loss_of_signal);
      bit_is("rx_frame_start", 1'b1, rx_frame_start);
      watch(80);
      check("rails high", 8'h0C, hi);
      wr(3'h6, 8'hFF);
      rd_check(3'h6, 8'h00);
      run <= 1'b0;
      for (int h = 0; h < 2; h++) begin
         tx_hold <= h[0];
         rx_hold <= ~h[0];
         idle(20);
         bit_is("tx_line_clock_out", h[0], tx_line_clock_out);
         bit_is("rx_output_clock", ~h[0], rx_output_clock);
      end
      run <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(`REG_MODE, 8'(m));
         idle(3);
         check("framing_mode", 8'((m == 1) ? FRAME_M23 : (m == 3) ?
               FRAME_CBIT : FRAME_E3), 8'(framing_mode));
      end
      nrz    <= 1'b1;
      rx_bit <= 1'b0;
      wr(`REG_MODE, 8'h00);
      wr(`REG_LINE, 8'h01);
      // Rails keep their last coded mark until the next transmit bit.
      idle(20);
      watch(80);
      bit_is("line_code_enable", 1'b0, line_code_enable);
      check("rails high", 8'h00, hi & 8'h0C);
      bit_is("rx_system_data", 1'b0, rx_system_data);
      tx_overhead_data   <= 1'b1;
      tx_overhead_enable <= 1'b1;
      idle(40);
      bit_is("tx_line_positive", 1'b1, tx_line_positive);
      tx_overhead_enable <= 1'b0;
      wr(`REG_LINE, 8'h05);
      idle(40);
      bit_is("tx_line_positive", 1'b0, tx_line_positive);
      bit_is("rx_system_data", 1'b1, rx_system_data);
      wr(`REG_LINE, 8'h03);
      idle(40);
      bit_is("tx_line_positive", 1'b1, tx_line_positive);
      wr(`REG_LOOP, 8'h01);
      idle(40);
      bit_is("tx_line_positive", 1'b0, tx_line_positive);
      wr(`REG_FORCE, 8'h01);
      idle(40);
      bit_is("tx_line_positive", 1'b1, tx_line_positive);
      wr(`REG_FORCE, 8'h00);
      rx_bit <= 1'b1;
      wr(`REG_LOOP, 8'h05);
      wr(`REG_LINE, 8'h01);
      idle(40);
      bit_is("tx_line_positive", 1'b1, tx_line_positive);
      bit_is("core_tx_bit", 1'b1, core_tx_bit);
      run     <= 1'b0;
      rx_hold <= 1'b1;
      tx_hold <= 1'b0;
      idle(20);
      bit_is("tx_line_clock_out", 1'b1, tx_line_clock_out);
      run <= 1'b1;
      wr(`REG_LOOP, 8'h04);
      rx_bit <= 1'b0;
      idle(40);
      bit_is("core_tx_bit", 1'b0, core_tx_bit);
      bit_is("tx_frame_start_out", 1'b1, tx_frame_start_out);
      tx_overhead_enable <= 1'b1;
      idle(40);
      bit_is("tx_line_positive", 1'b1, tx_line_positive);
      tx_overhead_enable <= 1'b0;
      rx_bit       <= 1'b0;
      tx_core_data <= 1'b1;
      wr(`REG_LOOP, 8'h02);
      idle(40);
      bit_is("rx_system_data", 1'b1, rx_system_data);
      rx_bit       <= 1'b1;
      tx_core_data <= 1'b0;
      idle(40);
      bit_is("rx_system_data", 1'b0, rx_system_data);
      wr(`REG_MODE, 8'h04);
      idle(40);
      bit_is("tx_line_positive", 1'b1, tx_line_positive);
      rx_core_enable <= 1'b1;
      wr(`REG_LOOP, 8'h00);
      watch(60);
      bit_is("rx_data_enable low", 1'b0, lo[1]);
      wr(`REG_SYSIF, 8'h02);
      watch(60);
      bit_is("rx_data_enable low", 1'b1, lo[1]);
      tx_core_enable <= 1'b1;
      wr(`REG_SYSIF, 8'h01);
      watch(60);
      check("tx_data_enable toggles", 8'h01, hi & lo & 8'h01);
      tx_core_enable <= 1'b0;
      wr(`REG_SYSIF, 8'h08);
      watch(60);
      check("tx_data_enable toggles", 8'h01, hi & lo & 8'h01);
      wr(`REG_SYSIF, 8'h04);
      idle(3);
      bit_is("tx_frame_start_oe", 1'b1, tx_frame_start_oe);
      finish_test();
   end
endmodule

// *** src/framer_channel_ctl.sv ***
// Channel mode, line format, loopback and overhead control for one framer.
// Overview of operation
// - Reset clears all control bits except unframed-ones and rx force-high.
// - After reset the channel runs E3, dual-rail, line coding enabled.
// - Unframed-ones bit drives all-ones onto the transmit line rails.
// - Receive force-high bit holds system receive data at one.
// - Line and receive output clocks are delayed noninverted clock copies.
// - Frame-start pin is an input at reset; status outputs are active high.
// - T3 and C-bit bits choose E3, DS3 M23 or DS3 C-bit parity.
// - Binary-format bit selects single-rail NRZ and disables line coding.
// - Enable pins are data enables unless their gapped-clock bit is set; constant-clock overrides the transmit enable pin.
// - Frame-start direction bit turns the transmit frame-start pin to output.
// - Line plus payload loopback drives transmit rails and clock from receive.
// - Line loopback returns receive rails, ignores alarms, honours force bits.
// - Diagnostic loopback feeds encoder output into the receive path.
// - Payload loopback clocks transmit from receive clock and receive data.
// - Payload loopback aligns transmit enable and frame start to receive.
// - Overhead enable replaces the outgoing bit with overhead data.
// - Constant-clock bit makes the transmit enable pin a running clock.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "framer_ctl_consts.svh"
module framer_channel_ctl (
   input  wire logic                       sys_clk,
   input  wire logic                       srst,
   input  wire logic [`ADDR_W-1:0]         reg_addr,
   input  wire logic [`DATA_W-1:0]         reg_wdata,
   input  wire logic                       reg_write,
   input  wire logic                       reg_read,
   output logic      [`DATA_W-1:0]         reg_rdata,
   input  wire logic                       tx_input_clock,
   input  wire logic                       tx_system_data,
   input  wire logic                       tx_overhead_data,
   input  wire logic                       tx_overhead_enable,
   input  wire logic                       tx_frame_start_in,
   output logic                            tx_frame_start_out,
   output logic                            tx_frame_start_oe,
   output logic                            tx_data_enable,
   output logic                            tx_line_positive,
   output logic                            tx_line_negative,
   output logic                            tx_line_clock_out,
   input  wire logic                       rx_line_clock,
   input  wire logic                       rx_line_positive,
   input  wire logic                       rx_line_negative,
   output logic                            rx_output_clock,
   output logic                            rx_system_data,
   output logic                            rx_data_enable,
   output logic                            rx_frame_start,
   output logic                            rx_loss_of_signal,
   output logic                            rx_out_of_frame,
   input  wire logic                       tx_core_data,
   input  wire logic                       tx_core_enable,
   input  wire logic                       tx_core_frame_start,
   input  wire logic                       rx_core_enable,
   input  wire logic                       rx_core_frame_start,
   input  wire logic                       rx_core_loss,
   input  wire logic                       rx_core_oof,
   output framer_ctl_pkg::framing_t        framing_mode,
   output logic                            line_code_enable,
   output logic                            core_tx_tick,
   output logic                            core_tx_bit,
   output logic                            core_tx_frame_start,
   output logic                            core_rx_tick,
   output logic                            core_rx_bit,
   output logic                            core_rx_violation
);
   import framer_ctl_pkg::*;

   typedef struct packed {
      logic [`CFG_REGS-1:0][`DATA_W-1:0] cfg;
      logic                              tx_clk_prev;
      logic                              rx_clk_prev;
      logic                              ami_tx_pos;
      logic                              ami_rx_pos;
      logic                              enc_pos;
      logic                              enc_neg;
      logic                              rx_bit;
      logic [`DATA_W-1:0]                rdata;
      logic                              tx_pos;
      logic                              tx_neg;
      logic                              tx_clk_out;
      logic                              rx_clk_out;
      logic                              rx_sys;
      logic                              tx_en;
      logic                              rx_en;
      logic                              sof_out;
      logic                              sof_oe;
      logic                              rx_sof;
      logic                              rx_los;
      logic                              rx_oof;
      framing_t                          mode;
      logic                              code_en;
      logic                              c_tx_tick;
      logic                              c_tx_bit;
      logic                              c_tx_sof;
      logic                              c_rx_tick;
      logic                              c_rx_bit;
      logic                              c_rx_viol;
   } state_t;

   state_t            st;
   state_t            next_st;
   logic [`PIN_W-1:0] syn;

   // Write mask of a configuration register; unmapped offsets store nothing.
   function automatic logic [`DATA_W-1:0] cfg_mask(
      input logic [`ADDR_W-1:0] a
   );
      unique case (a)
         `REG_MODE:  cfg_mask = `MODE_MASK;
         `REG_LINE:  cfg_mask = `LINE_MASK;
         `REG_SYSIF: cfg_mask = `SYS_MASK;
         `REG_LOOP:  cfg_mask = `LOOP_MASK;
         `REG_FORCE: cfg_mask = `FORCE_MASK;
         default:    cfg_mask = 8'h00;
      endcase
   endfunction

   function automatic framing_t framing_of(input logic [`DATA_W-1:0] m);
      if (!m[`MODE_T3]) begin
         framing_of = FRAME_E3;
      end else if (!m[`MODE_CBIT]) begin
         framing_of = FRAME_M23;
      end else begin
         framing_of = FRAME_CBIT;
      end
   endfunction

   framer_pin_sync #(
      .W (`PIN_W)
   ) u_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .d       ({rx_line_negative, rx_line_positive, rx_line_clock,
                 tx_frame_start_in, tx_overhead_enable, tx_overhead_data,
                 tx_system_data, tx_input_clock}),
      .q       (syn)
   );

   logic line_loopback;
   logic diag_loopback;
   logic payload_loopback;
   logic nrz;
   logic tx_clk_sel;
   logic tx_tick;
   logic rx_tick;
   logic tx_bit;
   logic tx_en_sel;

   assign line_loopback = st.cfg[`REG_LOOP][`LOOP_LINE];
   assign diag_loopback = st.cfg[`REG_LOOP][`LOOP_DIAG];
   assign payload_loopback = st.cfg[`REG_LOOP][`LOOP_PAYLOAD];
   assign nrz = st.cfg[`REG_LINE][`LINE_NRZ];
   // The transmit side follows the receive clock in payload loopback.
   assign tx_clk_sel = payload_loopback ? syn[`P_RXCLK] : syn[`P_TXCLK];
   assign tx_tick    = tx_clk_sel & ~st.tx_clk_prev;
   assign rx_tick    = syn[`P_RXCLK] & ~st.rx_clk_prev;
   // Overhead overrides core data; alarm forcing overrides both.
   assign tx_bit = (syn[`P_OHEN] ? syn[`P_OHD] : tx_core_data)
                 | st.cfg[`REG_LINE][`LINE_UNFRAMED]
                 | st.cfg[`REG_MODE][`MODE_ALARM];
   assign tx_en_sel = payload_loopback ? rx_core_enable : tx_core_enable;

   always_comb begin
      logic rp;
      logic rn;
      logic rt;
      logic p_raw;
      logic n_raw;
      rp    = 1'b0;
      rn    = 1'b0;
      rt    = 1'b0;
      p_raw = 1'b0;
      n_raw = 1'b0;
      next_st = st;
      if (srst) begin
         next_st                 = '0;
         next_st.cfg[`REG_LINE]  = `LINE_RESET;
         next_st.rx_sys          = 1'b1;
         next_st.mode            = FRAME_E3;
         next_st.code_en         = 1'b1;
      end else begin
         if (reg_write && reg_addr < `REG_STATUS) begin
            next_st.cfg[reg_addr] = reg_wdata & cfg_mask(reg_addr);
         end
         next_st.rdata = 8'h00;
         if (reg_read) begin
            if (reg_addr < `REG_STATUS) begin
               next_st.rdata = st.cfg[reg_addr];
            end else if (reg_addr == `REG_STATUS) begin
               next_st.rdata = {3'h0, st.rx_oof, st.rx_los, st.code_en,
                                st.mode};
            end
         end
         next_st.tx_clk_prev = tx_clk_sel;
         next_st.rx_clk_prev = syn[`P_RXCLK];
         next_st.c_tx_tick   = tx_tick;
         next_st.c_rx_tick   = 1'b0;
         if (tx_tick) begin
            next_st.c_tx_bit = payload_loopback ? st.rx_bit : syn[`P_TX_SYSTEM_DATA];
            if (nrz) begin
               next_st.enc_pos = tx_bit;
               next_st.enc_neg = 1'b0;
            end else if (tx_bit) begin
               // Alternate mark inversion keeps the line free of DC.
               next_st.enc_pos    = ~st.ami_tx_pos;
               next_st.enc_neg    = st.ami_tx_pos;
               next_st.ami_tx_pos = ~st.ami_tx_pos;
            end else begin
               next_st.enc_pos = 1'b0;
               next_st.enc_neg = 1'b0;
            end
         end
         rt = diag_loopback ? tx_tick : rx_tick;
         rp = diag_loopback ? next_st.enc_pos : syn[`P_RX_LINE_POSITIVE];
         rn = diag_loopback ? next_st.enc_neg : syn[`P_RX_LINE_NEGATIVE];
         if (rt) begin
            next_st.c_rx_tick = 1'b1;
            if (nrz) begin
               next_st.rx_bit    = rp;
               next_st.c_rx_viol = rn;
            end else begin
               next_st.rx_bit    = rp | rn;
               next_st.c_rx_viol = rp ? st.ami_rx_pos
                                  : (rn & ~st.ami_rx_pos);
               if (rp | rn) begin
                  next_st.ami_rx_pos = rp;
               end
            end
         end
         next_st.c_rx_bit = st.rx_bit;
         next_st.rx_sys = st.cfg[`REG_LINE][`LINE_RX_HIGH] | st.rx_bit;
         // Line loopback bypasses the encoder, so alarm forcing is lost.
         p_raw = line_loopback ? syn[`P_RX_LINE_POSITIVE] : st.enc_pos;
         n_raw = line_loopback ? syn[`P_RX_LINE_NEGATIVE] : st.enc_neg;
         next_st.tx_pos = st.cfg[`REG_FORCE][`FORCE_POS_HIGH]
                        | (p_raw ^ st.cfg[`REG_FORCE][`FORCE_POS_INV]);
         next_st.tx_neg = st.cfg[`REG_FORCE][`FORCE_NEG_HIGH]
                        | (n_raw ^ st.cfg[`REG_FORCE][`FORCE_NEG_INV]);
         next_st.tx_clk_out = (line_loopback | payload_loopback) ? syn[`P_RXCLK]
                                          : syn[`P_TXCLK];
         next_st.rx_clk_out = syn[`P_RXCLK];
         if (st.cfg[`REG_SYSIF][`SYS_CCLK]) begin
            next_st.tx_en = tx_clk_sel;
         end else if (st.cfg[`REG_SYSIF][`SYS_TX_GAP]) begin
            next_st.tx_en = tx_clk_sel & tx_en_sel;
         end else begin
            next_st.tx_en = tx_en_sel;
         end
         next_st.rx_en = st.cfg[`REG_SYSIF][`SYS_RX_GAP]
                       ? (syn[`P_RXCLK] & rx_core_enable)
                       : rx_core_enable;
         next_st.sof_oe  = st.cfg[`REG_SYSIF][`SYS_SOF_DIR];
         next_st.sof_out = payload_loopback ? rx_core_frame_start
                               : tx_core_frame_start;
         next_st.c_tx_sof = st.sof_oe ? st.sof_out : syn[`P_TX_FRAME_START];
         next_st.rx_sof  = rx_core_frame_start;
         next_st.rx_los  = rx_core_loss;
         next_st.rx_oof  = rx_core_oof;
         next_st.mode    = framing_of(st.cfg[`REG_MODE]);
         next_st.code_en = ~nrz;
      end
   end

   always_ff @(posedge sys_clk) begin
      st <= next_st;
   end

   assign reg_rdata           = st.rdata;
   assign tx_line_positive    = st.tx_pos;
   assign tx_line_negative    = st.tx_neg;
   assign tx_line_clock_out   = st.tx_clk_out;
   assign rx_output_clock     = st.rx_clk_out;
   assign rx_system_data      = st.rx_sys;
   assign tx_data_enable      = st.tx_en;
   assign rx_data_enable      = st.rx_en;
   assign tx_frame_start_out  = st.sof_out;
   assign tx_frame_start_oe   = st.sof_oe;
   assign rx_frame_start      = st.rx_sof;
   assign rx_loss_of_signal   = st.rx_los;
   assign rx_out_of_frame     = st.rx_oof;
   assign framing_mode        = st.mode;
   assign line_code_enable    = st.code_en;
   assign core_tx_tick        = st.c_tx_tick;
   assign core_tx_bit         = st.c_tx_bit;
   assign core_tx_frame_start = st.c_tx_sof;
   assign core_rx_tick        = st.c_rx_tick;
   assign core_rx_bit         = st.c_rx_bit;
   assign core_rx_violation   = st.c_rx_viol;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic quiet_tx;
   assign quiet_tx = nrz & ~line_loopback & (st.cfg[`REG_FORCE] == 8'h00) & ~reg_write;

   reset_value_a:
   assert property ($fell(srst) |-> st.cfg[`REG_LINE] == `LINE_RESET
      && st.cfg[`REG_LOOP] == 8'h00 && rx_system_data && line_code_enable)
      else $error("control bits wrong after reset");
   ones_force_a:
   assert property (tx_tick && quiet_tx && st.cfg[`REG_LINE][`LINE_UNFRAMED]
      ##1 quiet_tx |=> tx_line_positive && !tx_line_negative)
      else $error("unframed ones not on transmit rails");
   rx_high_a:
   assert property (st.cfg[`REG_LINE][`LINE_RX_HIGH] |=> rx_system_data)
      else $error("receive data not forced high");
   framing_sel_a:
   assert property (!reg_write [*2] |=> framing_mode
      == framing_of($past(st.cfg[`REG_MODE], 2)))
      else $error("framing mode does not follow mode bits");
   nrz_coding_a:
   assert property (nrz && !reg_write |=> ##1 !line_code_enable)
      else $error("line coding left on in binary format");
   sof_dir_a:
   assert property (st.cfg[`REG_SYSIF][`SYS_SOF_DIR] |=> tx_frame_start_oe)
      else $error("frame-start pin not turned to output");
   loop_clock_a:
   assert property (line_loopback && payload_loopback |=> tx_line_clock_out == $past(syn[`P_RXCLK]))
      else $error("line clock not from receive clock");
   line_loop_a:
   assert property (line_loopback && st.cfg[`REG_FORCE] == 8'h00
      |=> tx_line_positive == $past(syn[`P_RX_LINE_POSITIVE])
      && tx_line_negative == $past(syn[`P_RX_LINE_NEGATIVE]))
      else $error("line loopback rails not from receive rails");
   overhead_ins_a:
   assert property (tx_tick && syn[`P_OHEN] && quiet_tx
      && st.cfg[`REG_LINE][`LINE_UNFRAMED] == 1'b0
      && st.cfg[`REG_MODE][`MODE_ALARM] == 1'b0 ##1 quiet_tx
      |=> tx_line_positive == $past(syn[`P_OHD], 2))
      else $error("overhead bit not inserted");
   const_clock_a:
   assert property (st.cfg[`REG_SYSIF][`SYS_CCLK]
      |=> tx_data_enable == $past(tx_clk_sel))
      else $error("transmit enable pin not a running clock");
endmodule

// *** src/framer_ctl_consts.svh ***
// Register offsets, field positions, reset values and pin indices.
`ifndef FRAMER_CTL_CONSTS_SVH
`define FRAMER_CTL_CONSTS_SVH

`define ADDR_W          3
`define DATA_W          8
`define CFG_REGS        5

`define REG_MODE        3'h0
`define REG_LINE        3'h1
`define REG_SYSIF       3'h2
`define REG_LOOP        3'h3
`define REG_FORCE       3'h4
`define REG_STATUS      3'h5

`define MODE_T3         0
`define MODE_CBIT       1
`define MODE_ALARM      2
`define MODE_MASK       8'h07

`define LINE_NRZ        0
`define LINE_UNFRAMED   1
`define LINE_RX_HIGH    2
`define LINE_MASK       8'h07
`define LINE_RESET      8'h06

`define SYS_TX_GAP      0
`define SYS_RX_GAP      1
`define SYS_SOF_DIR     2
`define SYS_CCLK        3
`define SYS_MASK        8'h0F

`define LOOP_LINE       0
`define LOOP_DIAG       1
`define LOOP_PAYLOAD    2
`define LOOP_MASK       8'h07

`define FORCE_POS_HIGH  0
`define FORCE_POS_INV   1
`define FORCE_NEG_HIGH  2
`define FORCE_NEG_INV   3
`define FORCE_MASK      8'h0F

`define PIN_W           8
`define P_TXCLK         0
`define P_TX_SYSTEM_DATA          1
`define P_OHD           2
`define P_OHEN          3
`define P_TX_FRAME_START          4
`define P_RXCLK         5
`define P_RX_LINE_POSITIVE          6
`define P_RX_LINE_NEGATIVE          7

`endif

// *** src/framer_ctl_pkg.sv ***
// Types shared by the channel control block.
package framer_ctl_pkg;
   typedef enum logic [1:0] {
      FRAME_E3,
      FRAME_M23,
      FRAME_CBIT
   } framing_t;
endpackage

// *** src/framer_pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module framer_pin_sync #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_t;

   sync_t st;
   sync_t next_st;

   always_comb begin
      next_st = st;
      if (srst) begin
         next_st = '0;
      end else begin
         next_st.meta   = d;
         next_st.stable = st.meta;
      end
   end

   always_ff @(posedge sys_clk) begin
      st <= next_st;
   end

   assign q = st.stable;
endmodule
